// [hdl/tsh_pkg.sv]
/*
 Constants, register map and carrier types of the trigger sequencer
 with reading hold. Assumes a single 200 MHz instrument clock.
*/
`default_nettype none
package tsh_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_DELAY = 8'h04;
   localparam logic [7:0] OFS_COUNT = 8'h08;
   localparam logic [7:0] OFS_BEEP = 8'h0C;
   localparam logic [7:0] OFS_CMD = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_HELD = 8'h18;
   localparam logic [7:0] OFS_SEED = 8'h1C;
   // Command bits, write one to act
   localparam int CMD_INIT = 0;
   localparam int CMD_ABORT = 1;
   localparam int CMD_BUS_MANUAL_TRIGGER_KEY = 2;
   localparam int CMD_LIMIT_OFF = 3;
   // Count register fields
   localparam int CNT_HOLD_LSB = 0;
   localparam int CNT_FILT_LSB = 8;
   // Status register fields
   localparam int STS_HELD = 4;
   localparam int STS_LIMIT = 5;
   localparam int STS_SEED = 6;
   localparam int STS_CONS_LSB = 8;
   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int MS_NS = 1_000_000;
   localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
   localparam int OUT_PULSE_NS = 2000;
   localparam int OUT_PULSE_CYC = (OUT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [28:0] AUTO_SHORT_MS = 29'h0000_0001;
   localparam logic [28:0] AUTO_LONG_MS = 29'h0000_0005;
   localparam logic [28:0] MAX_DELAY_MS = 29'h159A_653F;
   // Ranges 10mV..100V as 0..4
   localparam logic [2:0] RANGE_LOW = 3'h0;
   localparam logic [2:0] RANGE_TOP = 3'h4;
   // Hold count and filter length limits, and reset values
   localparam logic [6:0] HOLD_CNT_MIN = 7'h02;
   localparam logic [6:0] HOLD_CNT_MAX = 7'h64;
   localparam logic [6:0] HOLD_CNT_RST = 7'h05;
   localparam logic [2:0] FILT_LOG_RST = 3'h0;
   localparam logic [2:0] FILT_LOG_MAX = 3'h4;
   localparam logic [28:0] DELAY_RST = 29'h0000_0000;
   // Window divisors for 0.01%, 0.1%, 1%, 10%
   localparam logic [13:0] WIN_DIV0 = 14'h2710;
   localparam logic [13:0] WIN_DIV1 = 14'h03E8;
   localparam logic [13:0] WIN_DIV2 = 14'h0064;
   localparam logic [13:0] WIN_DIV3 = 14'h000A;

   typedef enum logic [1:0] {BEEP_NEVER, BEEP_OUTSIDE, BEEP_INSIDE} tsh_beep_t;

   typedef struct packed {
      logic [17:0] rsvd;
      logic [1:0] window;
      logic [2:0] range;
      logic chan_two;
      logic func_temp;
      logic scanning;
      logic remote;
      logic filt_moving;
      logic filt_en;
      logic hold_en;
      logic auto_delay;
      logic ext_src;
   } tsh_cfg_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } tsh_apb_rsp_t;
endpackage
`default_nettype wire

// [hdl/tsh_trigger_sequencer.sv]
/*
 Trigger sequencer with filtering, reading hold and output trigger,
 reached over APB. Assumes the converter and relay driver share
 mclk_in; the trigger line and key arrive asynchronously.
*/
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tsh_trigger_sequencer #(
   parameter int CYC_MS = tsh_pkg::CYC_PER_MS
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output var tsh_pkg::tsh_apb_rsp_t apb_rsp_out,
   input wire logic external_trigger_input_in,
   input wire logic manual_trigger_key_in,
   output logic conv_start_out,
   input wire logic conv_valid_in,
   input wire logic signed [23:0] conv_data_in,
   output logic relay_step_out,
   input wire logic relay_done_in,
   output logic out_manual_trigger_key_out,
   output logic beep_out,
   output logic held_out,
   output logic signed [23:0] reading_out,
   output logic ch2_enable_out,
   output logic limit_en_out
);
   import tsh_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE, ST_WAIT_EVT, ST_DELAY, ST_CONV, ST_WAIT_CONV, ST_HOLD, ST_CHAN, ST_OUT
   } tsh_state_t;

   tsh_state_t state;
   tsh_cfg_t cfg;
   tsh_beep_t beep_mode;
   logic [28:0] man_delay;
   logic [6:0] hold_cnt;
   logic [2:0] filt_log;
   logic [6:0] cons;
   logic seed_valid;
   logic signed [23:0] seed;
   logic signed [23:0] rdg;
   logic rdg_rdy, conv_more, chan_wait;
   logic ext_s1, ext_s2, ext_prev, key_s1, key_s2, key_prev;
   logic [28:0] ms_left;
   logic [31:0] ms_div;
   logic [8:0] pulse_cnt;

   function automatic logic in_window(logic signed [23:0] r, logic signed [23:0] s,
                                      logic [1:0] w);
      logic signed [24:0] df;
      logic [24:0] d;
      logic [24:0] m;
      logic [13:0] k;
      df = {r[23], r} - {s[23], s};
      d = df[24] ? 25'(-df) : 25'(df);
      m = s[23] ? 25'(-{s[23], s}) : {1'b0, s};
      case (w)
         2'h0: k = WIN_DIV0;
         2'h1: k = WIN_DIV1;
         2'h2: k = WIN_DIV2;
         default: k = WIN_DIV3;
      endcase
      return (40'(d) * 40'(k)) <= 40'(m);
   endfunction

   function automatic logic [28:0] delay_ms(tsh_cfg_t c, logic [28:0] man);
      logic two;
      two = c.chan_two & ~c.hold_en;
      if (!c.auto_delay || c.func_temp) begin
         return man;
      end else if (!two) begin
         return (c.range == RANGE_TOP) ? AUTO_LONG_MS : AUTO_SHORT_MS;
      end else if (c.range == RANGE_LOW || c.range >= RANGE_TOP) begin
         return man;
      end else begin
         return AUTO_SHORT_MS;
      end
   endfunction

   // APB decode
   logic wr_en, setup;
   assign setup = psel_in & ~penable_in;
   assign wr_en = psel_in & penable_in & pwrite_in & apb_rsp_out.pready;
   logic cmd_wr, init_p, abort_p, bus_manual_trigger_key_p, limit_off_p, beep_wr;
   assign cmd_wr = wr_en & (paddr_in == OFS_CMD);
   assign init_p = cmd_wr & pwdata_in[CMD_INIT];
   assign abort_p = cmd_wr & pwdata_in[CMD_ABORT];
   assign bus_manual_trigger_key_p = cmd_wr & pwdata_in[CMD_BUS_MANUAL_TRIGGER_KEY];
   assign limit_off_p = cmd_wr & pwdata_in[CMD_LIMIT_OFF];
   assign beep_wr = wr_en & (paddr_in == OFS_BEEP);

   logic [31:0] status_word;
   assign status_word = {16'h0000, 1'b0, cons, 1'b0, seed_valid, limit_en_out, held_out,
                         4'(state)};

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         apb_rsp_out <= '0;
      end else begin
         apb_rsp_out.pready <= setup;
         if (setup) begin
            apb_rsp_out.pslverr <= 1'b0;
            case (paddr_in)
               OFS_CFG: apb_rsp_out.prdata <= cfg;
               OFS_DELAY: apb_rsp_out.prdata <= {3'h0, man_delay};
               OFS_COUNT: apb_rsp_out.prdata <= {21'h00_0000, filt_log, 1'b0, hold_cnt};
               OFS_BEEP: apb_rsp_out.prdata <= {30'h0000_0000, beep_mode};
               OFS_CMD: apb_rsp_out.prdata <= 32'h0000_0000;
               OFS_STATUS: apb_rsp_out.prdata <= status_word;
               OFS_HELD: apb_rsp_out.prdata <= 32'(reading_out);
               OFS_SEED: apb_rsp_out.prdata <= 32'(seed);
               default: begin
                  apb_rsp_out.prdata <= 32'h0000_0000;
                  apb_rsp_out.pslverr <= 1'b1;
               end
            endcase
         end
      end
   end

   // Configuration registers
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg <= '0;
         man_delay <= DELAY_RST;
         hold_cnt <= HOLD_CNT_RST;
         filt_log <= FILT_LOG_RST;
         beep_mode <= BEEP_NEVER;
      end else if (wr_en) begin
         case (paddr_in)
            OFS_CFG: cfg <= {18'h0_0000, pwdata_in[13:0]};
            OFS_DELAY: begin
               man_delay <= (pwdata_in > 32'(MAX_DELAY_MS)) ? MAX_DELAY_MS
                            : pwdata_in[28:0];
            end
            OFS_COUNT: begin
               if (pwdata_in[CNT_HOLD_LSB +: 7] < HOLD_CNT_MIN) begin
                  hold_cnt <= HOLD_CNT_MIN;
               end else if (pwdata_in[CNT_HOLD_LSB +: 7] > HOLD_CNT_MAX) begin
                  hold_cnt <= HOLD_CNT_MAX;
               end else begin
                  hold_cnt <= pwdata_in[CNT_HOLD_LSB +: 7];
               end
               filt_log <= (pwdata_in[CNT_FILT_LSB +: 3] > FILT_LOG_MAX) ? FILT_LOG_MAX
                           : pwdata_in[CNT_FILT_LSB +: 3];
            end
            OFS_BEEP: begin
               beep_mode <= (pwdata_in[1:0] == 2'h3) ? BEEP_INSIDE
                            : tsh_beep_t'(pwdata_in[1:0]);
            end
            default: ;
         endcase
      end
   end

   // Limit testing enable
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         limit_en_out <= 1'b0;
      end else if (beep_wr) begin
         limit_en_out <= 1'b1;
      end else if (limit_off_p) begin
         limit_en_out <= 1'b0;
      end
   end

   // Input synchronisers and edge detect
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         {ext_s1, ext_s2, ext_prev} <= 3'b111;
         {key_s1, key_s2, key_prev} <= 3'b000;
      end else begin
         ext_s1 <= external_trigger_input_in;
         ext_s2 <= ext_s1;
         ext_prev <= ext_s2;
         key_s1 <= manual_trigger_key_in;
         key_s2 <= key_s1;
         key_prev <= key_s2;
      end
   end

   logic ext_fall, key_press, evt;
   assign ext_fall = ext_prev & ~ext_s2;
   assign key_press = key_s2 & ~key_prev & ~cfg.remote;
   assign evt = ext_fall | key_press | bus_manual_trigger_key_p;

   // Hold verdict for the reading just produced
   logic win_ok, releasing;
   assign win_ok = in_window(rdg, seed, cfg.window);
   assign releasing = ~cfg.hold_en | (seed_valid & win_ok & ~held_out & (cons + 7'h01 >= hold_cnt));

   // Sequencer
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= ST_IDLE;
         ms_left <= DELAY_RST;
         ms_div <= 32'h0000_0000;
         conv_start_out <= 1'b0;
         relay_step_out <= 1'b0;
         chan_wait <= 1'b0;
      end else begin
         conv_start_out <= 1'b0;
         relay_step_out <= 1'b0;
         if (abort_p) begin
            state <= ST_IDLE;
            chan_wait <= 1'b0;
         end else begin
            case (state)
               ST_IDLE: if (init_p) state <= ST_WAIT_EVT;
               ST_WAIT_EVT: begin
                  // Events seen in any other state are simply dropped
                  if (!cfg.ext_src || evt) begin
                     state <= ST_DELAY;
                     ms_left <= delay_ms(cfg, man_delay);
                     ms_div <= 32'h0000_0000;
                  end
               end
               ST_DELAY: begin
                  if (ms_left == 29'h0000_0000) begin
                     state <= ST_CONV;
                  end else if (ms_div == 32'(CYC_MS - 1)) begin
                     ms_div <= 32'h0000_0000;
                     ms_left <= ms_left - 29'h0000_0001;
                  end else begin
                     ms_div <= ms_div + 32'h0000_0001;
                  end
               end
               ST_CONV: begin
                  conv_start_out <= 1'b1;
                  state <= ST_WAIT_CONV;
               end
               ST_WAIT_CONV: begin
                  if (rdg_rdy) state <= ST_HOLD;
                  else if (conv_more) state <= ST_CONV;
               end
               ST_HOLD: state <= releasing ? ST_CHAN : ST_CONV;
               ST_CHAN: begin
                  if (!cfg.scanning) begin
                     state <= ST_OUT;
                  end else if (!chan_wait) begin
                     relay_step_out <= 1'b1;
                     chan_wait <= 1'b1;
                  end else if (relay_done_in) begin
                     chan_wait <= 1'b0;
                     state <= ST_OUT;
                  end
               end
               ST_OUT: state <= ST_WAIT_EVT;
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // Filter
   logic signed [27:0] acc;
   logic [4:0] fill;
   logic [3:0] widx;
   logic signed [23:0] ring [16];
   logic [4:0] fsize;
   logic signed [27:0] nsum;
   assign fsize = 5'h01 << filt_log;
   // Oldest sample leaves only once the window is full; stale slots stay out
   assign nsum = acc + 28'(conv_data_in)
                 - ((cfg.filt_moving && fill >= fsize) ? 28'(ring[widx]) : 28'h000_0000);

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acc <= '0;
         fill <= '0;
         widx <= '0;
         rdg <= '0;
         rdg_rdy <= 1'b0;
         conv_more <= 1'b0;
         for (int i = 0; i < 16; i++) ring[i] <= '0;
      end else begin
         rdg_rdy <= 1'b0;
         conv_more <= 1'b0;
         if (abort_p || init_p) begin
            acc <= '0;
            fill <= '0;
            widx <= '0;
         end else if (state == ST_WAIT_CONV && conv_valid_in) begin
            if (!cfg.filt_en) begin
               rdg <= conv_data_in;
               rdg_rdy <= 1'b1;
            end else if (cfg.filt_moving) begin
               ring[widx] <= conv_data_in;
               acc <= nsum;
               widx <= (5'(widx) + 5'h01 >= fsize) ? 4'h0 : widx + 4'h1;
               if (fill + 5'h01 >= fsize) begin
                  fill <= fsize;
                  rdg <= 24'(nsum >>> filt_log);
                  rdg_rdy <= 1'b1;
               end else begin
                  fill <= fill + 5'h01;
                  conv_more <= 1'b1;
               end
            end else if (fill + 5'h01 >= fsize) begin
               rdg <= 24'(nsum >>> filt_log);
               rdg_rdy <= 1'b1;
               acc <= '0;
               fill <= '0;
            end else begin
               acc <= nsum;
               fill <= fill + 5'h01;
               conv_more <= 1'b1;
            end
         end
      end
   end

   // Reading hold
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         seed <= '0;
         seed_valid <= 1'b0;
         cons <= '0;
         held_out <= 1'b0;
         reading_out <= '0;
         beep_out <= 1'b0;
      end else begin
         beep_out <= 1'b0;
         if (abort_p || !cfg.hold_en) begin
            seed_valid <= 1'b0;
            cons <= '0;
            held_out <= 1'b0;
            if (state == ST_HOLD && !abort_p) reading_out <= rdg;
         end else if (state == ST_HOLD) begin
            if (!seed_valid) begin
               seed <= rdg;
               seed_valid <= 1'b1;
               cons <= '0;
            end else if (!win_ok) begin
               seed_valid <= 1'b0;
               cons <= '0;
               held_out <= 1'b0;
            end else if (!held_out) begin
               if (releasing) begin
                  cons <= hold_cnt;
                  held_out <= 1'b1;
                  reading_out <= rdg;
                  beep_out <= (beep_mode != BEEP_NEVER);
                  if (cfg.remote || cfg.scanning) begin
                     seed_valid <= 1'b0;
                     held_out <= 1'b0;
                  end
               end else begin
                  cons <= cons + 7'h01;
               end
            end
         end else if (state == ST_CHAN && chan_wait && relay_done_in) begin
            seed_valid <= 1'b0;
            cons <= '0;
         end
      end
   end

   // Output trigger and channel two gate
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pulse_cnt <= '0;
         out_manual_trigger_key_out <= 1'b0;
         ch2_enable_out <= 1'b1;
      end else begin
         ch2_enable_out <= ~cfg.hold_en;
         if (state == ST_OUT) begin
            pulse_cnt <= 9'(OUT_PULSE_CYC - 1);
            out_manual_trigger_key_out <= 1'b1;
         end else if (pulse_cnt != 9'h000) begin
            pulse_cnt <= pulse_cnt - 9'h001;
         end else begin
            out_manual_trigger_key_out <= 1'b0;
         end
      end
   end

   a_conv_in_seq: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      conv_start_out |-> $past(state) == ST_CONV) else $error("conversion outside sequence");
   a_imm_delay: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (state == ST_WAIT_EVT && !cfg.ext_src && !abort_p) |=> state == ST_DELAY)
      else $error("immediate source did not pass");
   a_key_remote: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      (state == ST_WAIT_EVT && cfg.ext_src && cfg.remote && !ext_fall && !bus_manual_trigger_key_p
       && !abort_p) |=> state == ST_WAIT_EVT) else $error("key accepted under remote");
   a_out_pulse: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      state == ST_OUT |=> out_manual_trigger_key_out [*8]) else $error("output trigger too short");
   a_beep_held: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      beep_out |-> $past(state) == ST_HOLD && $past(releasing) && cons == $past(hold_cnt))
      else $error("beep without release");
   a_ch2_off: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      cfg.hold_en |=> !ch2_enable_out) else $error("channel two left on");
   a_abort_idle: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      abort_p |=> state == ST_IDLE ##1 state == ST_IDLE || $past(init_p))
      else $error("abort did not idle");
   a_cons_bound: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      cons <= hold_cnt || $past(wr_en)) else $error("count above programmed value");
   a_limit_on: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      beep_wr |=> limit_en_out) else $error("limit testing not enabled");
endmodule // tsh_trigger_sequencer
`default_nettype wire

// [test/tsh_far_model.sv]
/* Converter and relay model on the far side of the sequencer.
 Assumes the sequencer clock and reset; latency comes from the bench. */
`timescale 1ns/1ps
`default_nettype none
module tsh_far_model (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic conv_start_in,
   input wire logic relay_step_in,
   input wire logic [3:0] lat_in,
   input wire logic signed [23:0] value_in,
   output logic conv_valid_out,
   output logic signed [23:0] conv_data_out,
   output logic relay_done_out
);
   logic [4:0] c_cnt;
   logic [4:0] r_cnt;
   // Data toggles outside the valid cycle
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         c_cnt <= 5'h00;
         r_cnt <= 5'h00;
         conv_valid_out <= 1'b0;
         relay_done_out <= 1'b0;
         conv_data_out <= 24'h00_0000;
      end else begin
         conv_valid_out <= (c_cnt == 5'h01);
         relay_done_out <= (r_cnt == 5'h01);
         conv_data_out <= (c_cnt == 5'h01) ? value_in : ~conv_data_out;
         c_cnt <= conv_start_in ? {1'b0, lat_in} + 5'h01 : c_cnt - {4'h0, c_cnt != 5'h00};
         r_cnt <= relay_step_in ? {1'b0, lat_in} + 5'h01 : r_cnt - {4'h0, r_cnt != 5'h00};
      end
   end
endmodule // tsh_far_model
`default_nettype wire

// [test/tsh_trigger_sequencer_tb_top.sv]
/* Bench top: APB master, far-side model, queued reading checks.
 Assumes tsh_pkg, the sequencer and tsh_far_model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tsh_trigger_sequencer_tb_top;
   import tsh_pkg::*;
   localparam int CM = 8;
   localparam logic [31:0] B = 32'h0000_0021;
   logic mclk, rst_n, psel, penable, pwrite, ext, key, cs, cv, rs, rd, ot, bp, hd, c2, le;
   logic [7:0] paddr;
   logic [31:0] pwdata, q;
   logic [3:0] lat;
   logic [15:0] lf;
   logic signed [23:0] val, cd, rdg;
   tsh_apb_rsp_t rsp;
   logic [23:0] exp_q[$];
   logic [31:0] cf[4] = '{32'h0000_0021, 32'h0000_0823, 32'h0000_0923, 32'h0000_00A3};
   int ml[4] = '{2, 4, 2, 2};
   int num_errors, n_tests, n_start, n_manual_trigger_key, n_beep, n_step, t_start, hi, cyc;
   int na, d, ns, d0, d1, w;
   tsh_trigger_sequencer #(.CYC_MS(CM)) dut (.mclk_in(mclk), .rst_n_in(rst_n), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .apb_rsp_out(rsp), .external_trigger_input_in(ext), .manual_trigger_key_in(key),
      .conv_start_out(cs), .conv_valid_in(cv), .conv_data_in(cd), .relay_step_out(rs),
      .relay_done_in(rd), .out_manual_trigger_key_out(ot), .beep_out(bp), .held_out(hd), .reading_out(rdg),
      .ch2_enable_out(c2), .limit_en_out(le));
   tsh_far_model far (.mclk_in(mclk), .rst_n_in(rst_n), .conv_start_in(cs), .relay_step_in(rs),
      .lat_in(lat), .value_in(val), .conv_valid_out(cv), .conv_data_out(cd), .relay_done_out(rd));
   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic apb(input logic w_in, input logic [7:0] a, input logic [31:0] dd);
      int i;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w_in;
      paddr <= a;
      pwdata <= dd;
      @(posedge mclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (rsp.pready !== 1'b1 && i < 40);
      q = rsp.prdata;
      if (i >= 40) begin
         num_errors++;
         end_sim();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic act(input logic [31:0] cfg, input logic [31:0] dl, input int how,
         input int e, input bit jmp);
      int i;
      int n0;
      int t0;
      int k;
      apb(1'b1, OFS_DELAY, dl);
      apb(1'b1, OFS_CFG, cfg);
      lf = nx(lf);
      val <= {8'h00, lf};
      lat <= lf[3:0] | 4'h2;
      if (e > 0) exp_q.push_back(jmp ? {7'h00, lf, 1'b0} : {8'h00, lf});
      n0 = n_start;
      k = n_manual_trigger_key;
      if (how > 1) apb(1'b1, OFS_CMD, how);
      t0 = cyc;
      for (i = 0; i < 3000 && n_manual_trigger_key == k; i++) begin
         @(posedge mclk);
         ext <= !(how == 0 && i < 6);
         key <= how == 1 && i < 6;
         if (jmp && n_start > n0 + 1) val <= {7'h00, lf, 1'b0};
      end
      if (e > 0 && n_manual_trigger_key == k) begin
         num_errors++;
         end_sim();
      end
      na = n_manual_trigger_key - k;
      d = t_start - t0;
      ns = n_start - n0;
      for (i = 0; i < 600 && ot !== 1'b0; i++) @(posedge mclk);
   endtask
   // Output watcher, sampled on the falling edge
   always @(negedge mclk) begin
      cyc++;
      if (cs === 1'b1) begin
         n_start++;
         t_start = cyc;
      end
      if (rs === 1'b1) n_step++;
      if (bp === 1'b1) n_beep++;
      if (ot === 1'b1) hi++;
      else if (hi > 0) begin
         chk(hi, OUT_PULSE_CYC);
         hi = 0;
      end
      if (hi == 1) begin
         n_manual_trigger_key++;
         if (exp_q.size() == 0) chk(32'h0000_0001, 32'h0000_0000);
         else chk({8'h00, rdg}, {8'h00, exp_q.pop_front()});
      end
   end
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      ext = 1'b1;
      key = 1'b0;
      lat = 4'h2;
      val = 24'h00_0000;
      lf = 16'h0053;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      apb(1'b0, OFS_COUNT, 32'h0000_0000);
      chk(q, {25'h000_0000, HOLD_CNT_RST});
      chk({31'h0000_0000, c2}, 32'h0000_0001);
      apb(1'b1, 8'h20, 32'h0000_0001);
      chk({31'h0000_0000, rsp.pslverr}, 32'h0000_0001);
      act(B, 32'h0000_0000, 0, 0, 0);
      chk(ns, 0);
      apb(1'b1, OFS_CMD, 32'h0000_0001);
      act(B, 32'h0000_0000, 0, 1, 0);
      chk(na, 1);
      act(B, 32'h0000_0000, 1, 0, 0);
      chk(na, 0);
      act(32'h0000_0001, 32'h0000_0000, 1, 1, 0);
      chk(na, 1);
      $display("event sources done");
      act(B | 32'h0000_0002, 32'h0000_0003, 4, 1, 0);
      d1 = d;
      for (w = 0; w < 4; w++) begin
         act(cf[w], 32'h0000_0003, 4, 1, 0);
         chk(d - d1, ml[w] * CM);
      end
      apb(1'b1, OFS_DELAY, 32'hFFFF_FFFF);
      apb(1'b0, OFS_DELAY, 32'h0000_0000);
      chk(q, {3'h0, MAX_DELAY_MS});
      $display("delay done");
      apb(1'b1, OFS_COUNT, 32'h0000_0102);
      act(B | 32'h0000_0008, 32'h0000_0000, 4, 1, 0);
      chk(ns, 2);
      // Moving average: two conversions fill the window of two
      act(B | 32'h0000_0018, 32'h0000_0000, 4, 1, 0);
      chk(ns, 2);
      d0 = n_step;
      act(B | 32'h0000_0040, 32'h0000_0000, 4, 1, 0);
      chk(n_step - d0, 1);
      $display("filter and step done");
      for (w = 0; w < 4; w++) begin
         apb(1'b1, OFS_CMD, 32'h0000_0008);
         apb(1'b1, OFS_BEEP, w);
         @(negedge mclk);
         chk({31'h0000_0000, le}, 32'h0000_0001);
         d0 = n_beep;
         act(B | 32'h0000_0004 | (w << 12), 32'h0000_0000, 4, 1, 0);
         chk(ns, 3);
         chk(n_beep - d0, w != 0);
         chk({31'h0000_0000, c2}, 32'h0000_0000);
      end
      act(B | 32'h0000_3004, 32'h0000_0000, 4, 1, 1);
      chk(ns, 5);
      act(32'h0000_3005, 32'h0000_0000, 4, 1, 0);
      chk({31'h0000_0000, hd}, 32'h0000_0001);
      $display("hold done");
      apb(1'b1, OFS_CMD, 32'h0000_0002);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      chk(q & 32'h0000_000F, 32'h0000_0000);
      d0 = n_start;
      repeat (200) @(posedge mclk);
      chk(n_start - d0, 0);
      act(32'h0000_0000, 32'h0000_0000, 5, 1, 0);
      chk(na, 1);
      apb(1'b1, OFS_CMD, 32'h0000_0002);
      $display("abort and immediate done");
      end_sim();
   end
endmodule // tsh_trigger_sequencer_tb_top
`default_nettype wire
